// ---- core/slave_status_and_command_queue.sv ----
// Command block interpreter: slave state table, event commands and command control.
// Summary of operation
// - Slave state codes: 0 idle, 1 active, 2 suspended.
// - Opening a channel sets slave state one.
// - Retry expiry sets two, loads suspend count.
// - Scans decrement suspended count; zero restores one.
// - Codes 3000/3100 request port slave status.
// - Status reply: id, 128 status words, echo.
// - Event codes 1000s port one, 2000s two.
// - Event words one to five give fields.
// - Swap code kept only for function three.
// - Event reply: word two success, echo code.
// - Event rejected only when queue holds 100.
// - Queued commands served before list entries.
// - List scan executes enable one or two.
// - Queued indexes run whatever their enable value.
// - Codes 5001-5006 port one, 5101-5106 two.
// - Lowest digit gives index count, words one up.
// - Control reply: word two counts added commands.
// - Reply word one returns the block identifier.
`timescale 1ns/1ps
`default_nettype none
module slave_status_and_command_queue #(
  parameter int NUM_SLAVES = sscq_pkg::NUM_SLAVES
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_srst,
  input  wire logic                      i_wr_valid,
  input  wire logic [7:0]                i_wr_idx,
  input  wire logic [15:0]               i_wr_data,
  input  wire logic                      i_wr_done,
  input  wire logic                      i_rd_ready,
  output var  logic                      o_rd_valid_ff,
  output var  logic [7:0]                o_rd_idx_ff,
  output var  logic [15:0]               o_rd_data_ff,
  output var  logic                      o_busy_ff,
  input  wire logic [1:0][15:0]          i_suspend_scan_count,
  input  wire logic [1:0]                i_chan_open,
  input  wire logic [1:0][4:0]           i_chan_open_addr,
  input  wire logic [1:0]                i_retry_expired,
  input  wire logic [1:0][4:0]           i_retry_expired_addr,
  input  wire logic [1:0]                i_cmd_scanned,
  input  wire logic [1:0][4:0]           i_cmd_scanned_addr,
  input  wire logic [1:0]                i_fetch,
  output var  logic [1:0]                o_entry_valid_ff,
  output var  sscq_pkg::entry_type [1:0] o_entry_ff,
  output var  logic [1:0]                o_queue_pending_ff,
  input  wire logic [1:0]                i_list_req,
  input  wire logic [1:0][1:0]           i_list_enable,
  output var  logic [1:0]                o_list_grant_ff,
  output var  logic [1:0][1:0]           o_slave_state_ff
);

  // ********************************
  // Declarations
  // ********************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVT  = 2'b01,
    ST_PUSH = 2'b10,
    ST_RESP = 2'b11
  } state_type;

  typedef enum logic [1:0] {
    KIND_STATUS = 2'b00,
    KIND_EVENT  = 2'b01,
    KIND_CC     = 2'b10
  } kind_type;

  state_type            state_ff;
  kind_type             kind_ff;
  logic                 port_ff;
  logic [2:0]           n_ff;
  logic [2:0]           i_ff;
  logic [2:0]           added_ff;
  logic                 ok_ff;
  logic [15:0]          code_ff;
  logic [7:0]           resp_idx_ff;
  logic [15:0]          w_ff [7];
  logic [1:0]           st_ff  [2][NUM_SLAVES];
  logic [15:0]          cnt_ff [2][NUM_SLAVES];
  logic [1:0]           push_req;
  sscq_pkg::entry_type  push_entry;
  logic [1:0]           full_vec;
  logic [1:0]           empty_vec;
  logic                 out_load;
  logic [15:0]          word_mux;
  logic [15:0]          w0;
  logic [15:0]          cc_digit1;
  logic [15:0]          cc_digit2;
  logic [6:0]           slv;

  queue_if qif [2] ();

  // ********************************
  // Per-port queues and fetch side
  // ********************************
  for (genvar p = 0; p < 2; p++) begin : g_port
    cmd_queue #(.DEPTH(sscq_pkg::QUEUE_DEPTH)) u_queue (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .q      (qif[p])
    );
    assign qif[p].push       = push_req[p];
    assign qif[p].push_entry = push_entry;
    assign qif[p].pop        = i_fetch[p] & ~qif[p].empty;
    assign full_vec[p]       = qif[p].full;
    assign empty_vec[p]      = qif[p].empty;

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        o_entry_valid_ff[p]   <= 1'b0;
        o_entry_ff[p]         <= '0;
        o_queue_pending_ff[p] <= 1'b0;
        o_list_grant_ff[p]    <= 1'b0;
      end else begin
        o_entry_valid_ff[p]   <= i_fetch[p] & ~qif[p].empty;
        if (i_fetch[p] && !qif[p].empty) begin
          o_entry_ff[p] <= qif[p].head;
        end
        o_queue_pending_ff[p] <= ~qif[p].empty;
        // A list entry is granted only while the queue is empty and it is enabled.
        o_list_grant_ff[p]    <= i_list_req[p] & qif[p].empty &
                                 ((i_list_enable[p] == 2'h1) || (i_list_enable[p] == 2'h2));
      end
    end
  end

  // ********************************
  // Block capture
  // ********************************
  assign w0        = w_ff[0];
  assign cc_digit1 = w0 - sscq_pkg::CODE_CC_P1_BASE;
  assign cc_digit2 = w0 - sscq_pkg::CODE_CC_P2_BASE;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int k = 0; k < 7; k++) begin
        w_ff[k] <= 16'h0000;
      end
    end else if (state_ff == ST_IDLE && i_wr_valid && i_wr_idx <= sscq_pkg::WORD_LAST_IN) begin
      w_ff[i_wr_idx[2:0]] <= i_wr_data;
    end
  end

  // ********************************
  // Command sequencer
  // ********************************
  always_comb begin
    push_req   = 2'b00;
    push_entry = '0;
    if (state_ff == ST_EVT) begin
      push_req[port_ff]   = ~full_vec[port_ff];
      push_entry.is_index = 1'b0;
      push_entry.data_loc = w_ff[sscq_pkg::EVT_DATA_LOC];
      push_entry.str_loc  = w_ff[sscq_pkg::EVT_STR_LOC];
      push_entry.func     = w_ff[sscq_pkg::EVT_FUNC];
      push_entry.remote   = w_ff[sscq_pkg::EVT_REMOTE];
      push_entry.swap     = (w_ff[sscq_pkg::EVT_FUNC] == sscq_pkg::FUNC_SWAP) ?
                            w_ff[sscq_pkg::EVT_SWAP] : 16'h0000;
    end else if (state_ff == ST_PUSH && i_ff < n_ff) begin
      push_req[port_ff]   = ~full_vec[port_ff];
      push_entry.is_index = 1'b1;
      push_entry.data_loc = w_ff[3'(i_ff + 3'h1)];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= ST_IDLE;
      kind_ff  <= KIND_STATUS;
      port_ff  <= 1'b0;
      n_ff     <= 3'h0;
      i_ff     <= 3'h0;
      added_ff <= 3'h0;
      ok_ff    <= 1'b0;
      code_ff  <= 16'h0000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          i_ff     <= 3'h0;
          added_ff <= 3'h0;
          if (i_wr_done) begin
            code_ff <= w0;
            if (w0 == sscq_pkg::CODE_STATUS_P1 || w0 == sscq_pkg::CODE_STATUS_P2) begin
              kind_ff  <= KIND_STATUS;
              port_ff  <= (w0 == sscq_pkg::CODE_STATUS_P2);
              state_ff <= ST_RESP;
            end else if (w0 >= sscq_pkg::CODE_EVT_P1_LO && w0 <= sscq_pkg::CODE_EVT_P2_HI) begin
              kind_ff  <= KIND_EVENT;
              port_ff  <= (w0 >= sscq_pkg::CODE_EVT_P2_LO);
              state_ff <= ST_EVT;
            end else if (w0 > sscq_pkg::CODE_CC_P1_BASE &&
                         cc_digit1 <= sscq_pkg::CC_MAX_COUNT) begin
              kind_ff  <= KIND_CC;
              port_ff  <= 1'b0;
              n_ff     <= cc_digit1[2:0];
              state_ff <= ST_PUSH;
            end else if (w0 > sscq_pkg::CODE_CC_P2_BASE &&
                         cc_digit2 <= sscq_pkg::CC_MAX_COUNT) begin
              kind_ff  <= KIND_CC;
              port_ff  <= 1'b1;
              n_ff     <= cc_digit2[2:0];
              state_ff <= ST_PUSH;
            end
          end
        end
        ST_EVT: begin
          ok_ff    <= ~full_vec[port_ff];
          state_ff <= ST_RESP;
        end
        ST_PUSH: begin
          // One index per cycle keeps the full flag exact for the next one.
          if (i_ff < n_ff) begin
            i_ff <= i_ff + 3'h1;
            if (!full_vec[port_ff]) begin
              added_ff <= added_ff + 3'h1;
            end
          end else begin
            state_ff <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (out_load && resp_idx_ff == sscq_pkg::WORD_ECHO) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ********************************
  // Reply stream
  // ********************************
  assign out_load = (state_ff == ST_RESP) && (!o_rd_valid_ff || i_rd_ready);
  assign slv      = 7'(resp_idx_ff - sscq_pkg::WORD_STAT_LO);

  always_comb begin
    word_mux = 16'h0000;
    if (resp_idx_ff == sscq_pkg::WORD_WR_ID || resp_idx_ff == sscq_pkg::WORD_ECHO) begin
      word_mux = code_ff;
    end else if (kind_ff == KIND_STATUS) begin
      if (resp_idx_ff >= sscq_pkg::WORD_STAT_LO && resp_idx_ff <= sscq_pkg::WORD_STAT_HI &&
          slv < 7'(NUM_SLAVES)) begin
        word_mux = {14'h0000, st_ff[port_ff][slv[4:0]]};
      end
    end else if (resp_idx_ff == sscq_pkg::WORD_RESULT) begin
      word_mux = (kind_ff == KIND_EVENT) ? {15'h0000, ok_ff} : {13'h0000, added_ff};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_valid_ff <= 1'b0;
      o_rd_idx_ff   <= 8'h00;
      o_rd_data_ff  <= 16'h0000;
      resp_idx_ff   <= 8'h00;
      o_busy_ff     <= 1'b0;
    end else begin
      o_busy_ff <= (state_ff != ST_IDLE) || o_rd_valid_ff || i_wr_done;
      if (state_ff != ST_RESP) begin
        resp_idx_ff <= 8'h00;
      end else if (out_load) begin
        resp_idx_ff <= resp_idx_ff + 8'h01;
      end
      if (out_load) begin
        o_rd_valid_ff <= 1'b1;
        o_rd_idx_ff   <= resp_idx_ff;
        o_rd_data_ff  <= word_mux;
      end else if (i_rd_ready) begin
        o_rd_valid_ff <= 1'b0;
      end
    end
  end

  // ********************************
  // Slave state table
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
          st_ff[p][s]  <= sscq_pkg::SLAVE_IDLE;
          cnt_ff[p][s] <= 16'h0000;
        end
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
          // A failure wins over an open or a scan landing in the same cycle.
          if (i_retry_expired[p] && i_retry_expired_addr[p] == 5'(s)) begin
            st_ff[p][s]  <= sscq_pkg::SLAVE_SUSPENDED;
            cnt_ff[p][s] <= i_suspend_scan_count[p];
          end else if (i_chan_open[p] && i_chan_open_addr[p] == 5'(s)) begin
            st_ff[p][s]  <= sscq_pkg::SLAVE_ACTIVE;
          end else if (i_cmd_scanned[p] && i_cmd_scanned_addr[p] == 5'(s) &&
                       st_ff[p][s] == sscq_pkg::SLAVE_SUSPENDED) begin
            if (cnt_ff[p][s] <= 16'h0001) begin
              cnt_ff[p][s] <= 16'h0000;
              st_ff[p][s]  <= sscq_pkg::SLAVE_ACTIVE;
            end else begin
              cnt_ff[p][s] <= cnt_ff[p][s] - 16'h0001;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_slave_state_ff <= '0;
    end else begin
      o_slave_state_ff[0] <= st_ff[0][i_cmd_scanned_addr[0]];
      o_slave_state_ff[1] <= st_ff[1][i_cmd_scanned_addr[1]];
    end
  end

  // ********************************
  // Checks
  // ********************************
  AST_FAIL_SUSPENDS: assert property (@(posedge i_clk) disable iff (i_srst)
    i_retry_expired[0] |=> st_ff[0][$past(i_retry_expired_addr[0])] == sscq_pkg::SLAVE_SUSPENDED)
    else $error("Retry expiry did not suspend the slave.");
  AST_OPEN_ACTIVE: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_chan_open[1] && !i_retry_expired[1]) |=>
      st_ff[1][$past(i_chan_open_addr[1])] == sscq_pkg::SLAVE_ACTIVE)
    else $error("Opened slave is not active.");
  AST_EVT_FULL_REJECT: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_ff == ST_EVT) |-> (push_req[port_ff] == !full_vec[port_ff]) ##1 (ok_ff == $past(push_req[port_ff])))
    else $error("Event accept does not match queue space.");
  AST_QUEUE_FIRST: assert property (@(posedge i_clk) disable iff (i_srst)
    o_list_grant_ff[0] |-> $past(empty_vec[0]))
    else $error("List entry granted while queue held commands.");
  AST_ENABLE_ZERO: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_list_req[1] && i_list_enable[1] == 2'h0) |=> !o_list_grant_ff[1])
    else $error("Disabled list entry was granted.");
  AST_ECHO_CODE: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_rd_valid_ff && (o_rd_idx_ff == sscq_pkg::WORD_ECHO || o_rd_idx_ff == sscq_pkg::WORD_WR_ID))
      |-> o_rd_data_ff == code_ff)
    else $error("Reply identifier word is not the block code.");
  AST_CC_COUNT: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_ff == ST_PUSH && i_ff == n_ff) |-> (added_ff <= n_ff) ##1 (state_ff == ST_RESP))
    else $error("Command control count out of range.");
  AST_ROUTE_PORT2: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_ff == ST_IDLE && i_wr_done && w0 >= sscq_pkg::CODE_EVT_P2_LO &&
     w0 <= sscq_pkg::CODE_EVT_P2_HI) |=> (port_ff && state_ff == ST_EVT))
    else $error("Event block in the 2000 range not sent to port two.");
  AST_SWAP_ONLY_F3: assert property (@(posedge i_clk) disable iff (i_srst)
    (|push_req && !push_entry.is_index && push_entry.func != sscq_pkg::FUNC_SWAP)
      |-> push_entry.swap == 16'h0000)
    else $error("Swap code kept for a function other than three.");

endmodule : slave_status_and_command_queue
`default_nettype wire

// ---- core/sscq_pkg.sv ----
// Package with block codes, word positions, slave states and queue entry layout.
package sscq_pkg;

  // ********************************
  // Block codes
  // ********************************
  localparam logic [15:0] CODE_STATUS_P1  = 16'h0bb8;
  localparam logic [15:0] CODE_STATUS_P2  = 16'h0c1c;
  localparam logic [15:0] CODE_EVT_P1_LO  = 16'h03e8;
  localparam logic [15:0] CODE_EVT_P1_HI  = 16'h07cf;
  localparam logic [15:0] CODE_EVT_P2_LO  = 16'h07d0;
  localparam logic [15:0] CODE_EVT_P2_HI  = 16'h0bb7;
  localparam logic [15:0] CODE_CC_P1_BASE = 16'h1388;
  localparam logic [15:0] CODE_CC_P2_BASE = 16'h13ec;
  localparam logic [15:0] CC_MAX_COUNT    = 16'h0006;
  localparam logic [15:0] FUNC_SWAP       = 16'h0003;

  // ********************************
  // Word positions
  // ********************************
  localparam logic [7:0] WORD_CODE      = 8'h00;
  localparam logic [7:0] WORD_LAST_IN   = 8'h06;
  localparam logic [7:0] WORD_WR_ID     = 8'h01;
  localparam logic [7:0] WORD_RESULT    = 8'h02;
  localparam logic [7:0] WORD_STAT_LO   = 8'h02;
  localparam logic [7:0] WORD_STAT_HI   = 8'h81;
  localparam logic [7:0] WORD_ECHO      = 8'hf9;
  localparam logic [2:0] EVT_DATA_LOC   = 3'h1;
  localparam logic [2:0] EVT_STR_LOC    = 3'h2;
  localparam logic [2:0] EVT_SWAP       = 3'h3;
  localparam logic [2:0] EVT_FUNC       = 3'h4;
  localparam logic [2:0] EVT_REMOTE     = 3'h5;

  // ********************************
  // Slave states and sizes
  // ********************************
  localparam logic [1:0] SLAVE_IDLE      = 2'h0;
  localparam logic [1:0] SLAVE_ACTIVE    = 2'h1;
  localparam logic [1:0] SLAVE_SUSPENDED = 2'h2;
  localparam int         QUEUE_DEPTH     = 100;
  localparam int         NUM_SLAVES      = 32;
  localparam int         COUNT_W         = 7;

  typedef struct packed {
    logic        is_index;
    logic [15:0] data_loc;
    logic [15:0] str_loc;
    logic [15:0] swap;
    logic [15:0] func;
    logic [15:0] remote;
  } entry_type;

endpackage : sscq_pkg

// ---- core/queue_if.sv ----
// Interface between the interpreter and one port's command queue.
`timescale 1ns/1ps
`default_nettype none
interface queue_if;
  logic                               push;
  sscq_pkg::entry_type                push_entry;
  logic                               pop;
  sscq_pkg::entry_type                head;
  logic [sscq_pkg::COUNT_W-1:0]       count;
  logic                               full;
  logic                               empty;
  modport mgr   (output push, push_entry, pop, input head, count, full, empty);
  modport store (input push, push_entry, pop, output head, count, full, empty);
endinterface : queue_if
`default_nettype wire

// ---- core/cmd_queue.sv ----
// Circular command queue for one port.
`timescale 1ns/1ps
`default_nettype none
module cmd_queue #(
  parameter int DEPTH = sscq_pkg::QUEUE_DEPTH
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  queue_if.store    q
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  sscq_pkg::entry_type mem [DEPTH];
  logic [PW-1:0]                 wr_ptr_ff;
  logic [PW-1:0]                 rd_ptr_ff;
  logic [sscq_pkg::COUNT_W-1:0]  count_ff;
  logic                          do_push;
  logic                          do_pop;

  assign q.full    = (count_ff == sscq_pkg::COUNT_W'(DEPTH));
  assign q.empty   = (count_ff == '0);
  assign q.count   = count_ff;
  assign q.head    = mem[rd_ptr_ff];
  // A push into a full queue is dropped, so the count never passes the depth.
  assign do_push   = q.push & ~q.full;
  assign do_pop    = q.pop & ~q.empty;

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= q.push_entry;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule : cmd_queue
`default_nettype wire

// ---- bench/ctrl_model.sv ----
// Controller model: sends write blocks and collects reply words.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd_valid,
  input  wire logic [7:0]  i_rd_idx,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_busy,
  output var  logic        o_wr_valid,
  output var  logic [7:0]  o_wr_idx,
  output var  logic [15:0] o_wr_data,
  output var  logic        o_wr_done,
  output var  logic        o_rd_ready
);
  logic [15:0] reply [0:249];
  int          got;
  initial begin
    o_wr_valid = 1'b0;
    o_wr_idx   = 8'h00;
    o_wr_data  = 16'h0000;
    o_wr_done  = 1'b0;
    o_rd_ready = 1'b0;
  end
  // Ready stalls at random so replies are taken both promptly and slowly.
  always @(posedge i_clk) begin
    #1;
    o_rd_ready = ($urandom % 4) != 0;
  end
  always @(posedge i_clk) begin
    if (i_rd_valid && o_rd_ready) begin
      reply[i_rd_idx] <= i_rd_data;
      got             <= got + 1;
    end
  end
  // Word 0 carries the block code and goes ahead of the done strobe.
  task automatic send(input logic [15:0] w [0:6], output bit ok);
    got = 0;
    for (int i = 0; i < 7; i++) begin
      o_wr_valid = 1'b1;
      o_wr_idx   = i[7:0];
      o_wr_data  = w[i];
      @(posedge i_clk);
      #1;
    end
    o_wr_valid = 1'b0;
    o_wr_data  = ~o_wr_data;
    o_wr_done  = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr_done = 1'b0;
    ok = 1'b0;
    for (int n = 0; n < 3000 && !ok; n++) begin
      @(posedge i_clk);
      #1;
      ok = (got == 250) && !i_busy;
    end
  endtask : send
endmodule : ctrl_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the command block interpreter.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0, i_srst = 1'b1, i_wr_valid, i_wr_done, i_rd_ready, o_rd_valid_ff, o_busy_ff;
  logic [7:0] i_wr_idx, o_rd_idx_ff;
  logic [15:0] i_wr_data, o_rd_data_ff;
  logic [1:0][15:0] i_suspend_scan_count = {16'h0001, 16'h0002};
  logic [1:0] i_chan_open = '0, i_retry_expired = '0, i_cmd_scanned = '0, i_fetch = '0;
  logic [1:0] i_list_req = '0, o_entry_valid_ff, o_queue_pending_ff, o_list_grant_ff;
  logic [1:0][4:0] i_chan_open_addr = '0, i_retry_expired_addr = '0, i_cmd_scanned_addr = '0;
  logic [1:0][1:0] i_list_enable = '0, o_slave_state_ff;
  sscq_pkg::entry_type [1:0] o_entry_ff;
  logic [1:0] exp_state [2][32];
  logic [15:0] w [0:6];
  int mismatches = 0, num_checks = 0, cycles = 0;
  bit ok;
  always #5 i_clk = ~i_clk;
  slave_status_and_command_queue slave_status_and_command_queue_inst (
    .i_clk, .i_srst, .i_wr_valid, .i_wr_idx, .i_wr_data, .i_wr_done, .i_rd_ready,
    .o_rd_valid_ff, .o_rd_idx_ff, .o_rd_data_ff, .o_busy_ff, .i_suspend_scan_count,
    .i_chan_open, .i_chan_open_addr, .i_retry_expired, .i_retry_expired_addr, .i_cmd_scanned,
    .i_cmd_scanned_addr, .i_fetch, .o_entry_valid_ff, .o_entry_ff, .o_queue_pending_ff,
    .i_list_req, .i_list_enable, .o_list_grant_ff, .o_slave_state_ff);
  ctrl_model ctrl_model_inst (.i_clk, .i_rd_valid(o_rd_valid_ff), .i_rd_idx(o_rd_idx_ff),
    .i_rd_data(o_rd_data_ff), .i_busy(o_busy_ff), .o_wr_valid(i_wr_valid), .o_wr_idx(i_wr_idx),
    .o_wr_data(i_wr_data), .o_wr_done(i_wr_done), .o_rd_ready(i_rd_ready));
  task automatic check(input logic [80:0] seen, input logic [80:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // The ceiling allows about three times the expected run of some 40 blocks.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick
  task automatic block(input logic [15:0] code, input logic [15:0] w2, input bit st, input int p);
    logic [15:0] e;
    w[0] = code;
    ctrl_model_inst.send(w, ok);
    check(ok, 1'b1);
    for (int i = 0; i < 250; i++) begin
      e = (i == 1 || i == 249) ? code : 16'h0000;
      if (st && i >= 2 && i < 34) e = {14'h0000, exp_state[p][i-2]};
      if (!st && i == 2) e = w2;
      check(ctrl_model_inst.reply[i], e);
    end
  endtask : block
  task automatic slave_ev(input int kind, input int p, input logic [4:0] a);
    case (kind)
      0: begin i_chan_open[p] = 1'b1; i_chan_open_addr[p] = a; end
      1: begin i_retry_expired[p] = 1'b1; i_retry_expired_addr[p] = a; end
      default: begin i_cmd_scanned[p] = 1'b1; i_cmd_scanned_addr[p] = a; end
    endcase
    tick();
    i_chan_open = '0;
    i_retry_expired = '0;
    i_cmd_scanned = '0;
    tick();
    if (kind > 1) check(o_slave_state_ff[p], exp_state[p][a]);
  endtask : slave_ev
  task automatic pop(input int p, input logic v, input sscq_pkg::entry_type e, input int m);
    i_fetch[p] = 1'b1;
    tick();
    i_fetch = '0;
    check(o_entry_valid_ff[p], v);
    if (m == 0) check(o_entry_ff[p], e);
    if (m == 1) check({o_entry_ff[p].is_index, o_entry_ff[p].data_loc}, {1'b1, e.data_loc});
    tick();
  endtask : pop
  task automatic grant_chk(input int p, input logic [1:0] en, input logic g);
    i_list_req[p] = 1'b1;
    i_list_enable[p] = en;
    tick();
    check(o_list_grant_ff[p], g);
    i_list_req = '0;
    tick();
  endtask : grant_chk
  initial begin
    sscq_pkg::entry_type e;
    logic [15:0] fn [5] = '{16'h0003, 16'h0007, 16'h000b, 16'h000c, 16'h000d};
    logic [4:0] a;
    void'($urandom(32'hd906));
    foreach (exp_state[p, s]) exp_state[p][s] = 2'h0;
    w = '{default: 16'h0000};
    repeat (12) @(posedge i_clk);
    #1 i_srst = 1'b0;
    check({o_rd_valid_ff, o_busy_ff, o_queue_pending_ff, o_slave_state_ff}, '0);
    for (int k = 0; k < 4; k++) begin
      a = 5'($urandom % 32);
      slave_ev(0, k % 2, a);
      exp_state[k % 2][a] = 2'h1;
    end
    slave_ev(1, 0, 5'h05);
    slave_ev(1, 1, 5'h09);
    exp_state[0][5] = 2'h2;
    exp_state[1][9] = 2'h2;
    slave_ev(2, 0, 5'h05);
    block(sscq_pkg::CODE_STATUS_P1, 16'h0000, 1'b1, 0);
    exp_state[0][5] = 2'h1;
    slave_ev(2, 0, 5'h05);
    block(sscq_pkg::CODE_STATUS_P1, 16'h0000, 1'b1, 0);
    block(sscq_pkg::CODE_STATUS_P2, 16'h0000, 1'b1, 1);
    exp_state[1][9] = 2'h1;
    slave_ev(2, 1, 5'h09);
    $display("test slave status done");
    for (int k = 0; k < 5; k++) begin
      for (int i = 1; i < 6; i++) w[i] = 16'($urandom);
      w[4] = fn[k];
      block(16'(1000 * (k % 2 + 1) + $urandom % 1000), 16'h0001, 1'b0, 0);
      e = '{1'b0, w[1], w[2], (k == 0) ? w[3] : 16'h0000, w[4], w[5]};
      pop(k % 2, 1'b1, e, 0);
    end
    $display("test event commands done");
    for (int p = 0; p < 2; p++) begin
      for (int n = 1; n <= 6; n++) begin
        for (int i = 1; i < 7; i++) w[i] = 16'($urandom % 100);
        block(16'(5000 + 100 * p + n), 16'(n), 1'b0, p);
        for (int i = 1; i <= n; i++) pop(p, 1'b1, '{1'b1, w[i], 16'h0, 16'h0, 16'h0, 16'h0}, 1);
      end
    end
    $display("test command control done");
    for (int k = 0; k < 17; k++) begin
      for (int i = 1; i < 7; i++) w[i] = 16'($urandom % 100);
      block(16'd5006, (k == 16) ? 16'h0004 : 16'h0006, 1'b0, 0);
    end
    block(16'd1000, 16'h0000, 1'b0, 0);
    check(o_queue_pending_ff[0], 1'b1);
    grant_chk(0, 2'h1, 1'b0);
    for (int k = 0; k < 100; k++) pop(0, 1'b1, e, 2);
    pop(0, 1'b0, e, 2);
    check(o_queue_pending_ff[0], 1'b0);
    for (int p = 0; p < 2; p++) begin
      for (int en = 0; en < 4; en++) grant_chk(p, 2'(en), en == 1 || en == 2);
    end
    $display("test queue fill and list grant done");
    summarize();
  end
endmodule : tb
`default_nettype wire
